// *** hdl/dbmp_defs.svh ***
/*
 * Constants of the data-space bus master priority block: register indices,
 * field positions, implemented-bit masks, reset values and master indices.
 * Assumes it is included by its bare name from the package and modules.
 */
`ifndef DBMP_DEFS_SVH
`define DBMP_DEFS_SVH

// ==========================================================================
// Register port
`define DBMP_ADDR_W 4
`define DBMP_DATA_W 16
`define DBMP_ADDR_MAIN 4'h0
`define DBMP_ADDR_SEC 4'h1

// ==========================================================================
// Priority control fields
`define DBMP_BIT_DMA 5
`define DBMP_BIT_CAN 4
`define DBMP_BIT_NVM 0
`define DBMP_MASK_MAIN 16'h0031
`define DBMP_MASK_SEC 16'h0020
`define DBMP_RST_VAL 16'h0000
`define DBMP_RDATA_IDLE 16'h0000

// ==========================================================================
// Bus master indices in request and grant vectors
`define DBMP_NMST 4
`define DBMP_MST_CPU 0
`define DBMP_MST_DMA 1
`define DBMP_MST_CAN 2
`define DBMP_MST_NVM 3

`endif

// *** hdl/dbmp_pkg.sv ***
/*
 * Types of the data-space bus master priority block.
 * Assumes dbmp_defs.svh is on the include path.
 */
`include "dbmp_defs.svh"

package dbmp_pkg;
	typedef logic [`DBMP_DATA_W-1:0] dbmp_word_t;
	typedef logic [`DBMP_ADDR_W-1:0] dbmp_addr_t;
	typedef logic [`DBMP_NMST-1:0] dbmp_mvec_t;
endpackage

// *** hdl/dbmp_arbiter.sv ***
/*
 * Fixed-priority data-space bus arbiter for one core, steered by the
 * priority-raise bits of that core's control register.
 * Assumes requests are synchronous to the core clock; grant is combinational.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbmp_defs.svh"

module dbmp_arbiter
	import dbmp_pkg::*;
(
	input wire dbmp_mvec_t i_req,
	input wire dbmp_mvec_t i_raise,
	output dbmp_mvec_t o_gnt
);

	// ======================================================================
	// Grant selection
	// Raised masters first, then the CPU, then the remaining masters.
	always_comb begin
		o_gnt = '0;
		for (int i = `DBMP_NMST - 1; i >= 1; i--) begin
			if (i_req[i] && !i_raise[i]) begin
				o_gnt = '0;
				o_gnt[i] = 1'b1;
			end
		end
		if (i_req[`DBMP_MST_CPU]) begin
			o_gnt = '0;
			o_gnt[`DBMP_MST_CPU] = 1'b1;
		end
		for (int i = `DBMP_NMST - 1; i >= 1; i--) begin
			if (i_req[i] && i_raise[i]) begin
				o_gnt = '0;
				o_gnt[i] = 1'b1;
			end
		end
	end

endmodule // dbmp_arbiter

`default_nettype wire

// *** hdl/dbmp_top.sv ***
/*
 * Data-space bus master priority control for a dual-core controller:
 * one priority control register per core and one arbiter per core.
 * Assumes a single-cycle register port and synchronous master requests.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbmp_defs.svh"

module dbmp_top
	import dbmp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire dbmp_addr_t i_addr,
	input wire dbmp_word_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output dbmp_word_t o_rdata,
	input wire dbmp_mvec_t i_main_req,
	output dbmp_mvec_t o_main_gnt,
	input wire logic [1:0] i_sec_req,
	output logic [1:0] o_sec_gnt
);

	// ======================================================================
	// Helpers
	function automatic dbmp_word_t mask_write(input dbmp_word_t data,
		input dbmp_word_t mask);
		mask_write = data & mask;
	endfunction

	function automatic dbmp_mvec_t raise_vec(input dbmp_word_t ctrl);
		dbmp_mvec_t v;
		v = '0;
		v[`DBMP_MST_DMA] = ctrl[`DBMP_BIT_DMA];
		v[`DBMP_MST_CAN] = ctrl[`DBMP_BIT_CAN];
		v[`DBMP_MST_NVM] = ctrl[`DBMP_BIT_NVM];
		raise_vec = v;
	endfunction

	// ======================================================================
	// Priority control registers
	dbmp_word_t main_ctrl_q;
	dbmp_word_t sec_ctrl_q;
	dbmp_word_t rdata_q;

	// Only implemented bits are ever stored, so unimplemented ones read zero
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			main_ctrl_q <= `DBMP_RST_VAL;
		end else if (i_wr && i_addr == `DBMP_ADDR_MAIN) begin
			main_ctrl_q <= mask_write(i_wdata, `DBMP_MASK_MAIN);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sec_ctrl_q <= `DBMP_RST_VAL;
		end else if (i_wr && i_addr == `DBMP_ADDR_SEC) begin
			sec_ctrl_q <= mask_write(i_wdata, `DBMP_MASK_SEC);
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_rd) begin
			rdata_q <= `DBMP_RDATA_IDLE;
		end else begin
			case (i_addr)
				`DBMP_ADDR_MAIN: rdata_q <= main_ctrl_q;
				`DBMP_ADDR_SEC: rdata_q <= sec_ctrl_q;
				default: rdata_q <= `DBMP_RDATA_IDLE;
			endcase
		end
	end

	assign o_rdata = rdata_q;

	// ======================================================================
	// Arbiters
	dbmp_mvec_t sec_req_v;
	dbmp_mvec_t sec_gnt_v;
	dbmp_mvec_t sec_raise_v;

	// Secondary core has no CAN or NVM master on its bus
	assign sec_req_v = {2'b00, i_sec_req};
	assign sec_raise_v = raise_vec(mask_write(sec_ctrl_q, `DBMP_MASK_SEC));

	// No bus lock: grants are re-arbitrated every cycle, so a raised master can split a burst
	dbmp_arbiter u_main_arb (
		.i_req(i_main_req),
		.i_raise(raise_vec(main_ctrl_q)),
		.o_gnt(o_main_gnt)
	);

	dbmp_arbiter u_sec_arb (
		.i_req(sec_req_v),
		.i_raise(sec_raise_v),
		.o_gnt(sec_gnt_v)
	);

	assign o_sec_gnt = sec_gnt_v[1:0];

	// ======================================================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	property p_dma_main_raised;
		main_ctrl_q[`DBMP_BIT_DMA] && i_main_req[`DBMP_MST_DMA]
			|-> o_main_gnt[`DBMP_MST_DMA] && !o_main_gnt[`DBMP_MST_CPU];
	endproperty
	a_dma_main_raised: assert property (p_dma_main_raised)
		else $error("raised DMA not granted on main bus");

	property p_can_main_raised;
		main_ctrl_q[`DBMP_BIT_CAN] && i_main_req[`DBMP_MST_CAN]
			&& i_main_req[`DBMP_MST_CPU] |-> !o_main_gnt[`DBMP_MST_CPU];
	endproperty
	a_can_main_raised: assert property (p_can_main_raised)
		else $error("CPU granted over raised CAN");

	property p_nvm_main_raised;
		main_ctrl_q[`DBMP_BIT_NVM] && (i_main_req == 4'h9)
			|-> o_main_gnt == 4'h8;
	endproperty
	a_nvm_main_raised: assert property (p_nvm_main_raised)
		else $error("raised NVM not granted over CPU");

	property p_main_unimpl_zero;
		i_rd && i_addr == `DBMP_ADDR_MAIN
			|=> (o_rdata & ~`DBMP_MASK_MAIN) == 16'h0000;
	endproperty
	a_main_unimpl_zero: assert property (p_main_unimpl_zero)
		else $error("main register unimplemented bit read nonzero");

	property p_sec_only_dma;
		i_rd && i_addr == `DBMP_ADDR_SEC |=> (o_rdata & ~`DBMP_MASK_SEC) == 16'h0000;
	endproperty
	a_sec_only_dma: assert property (p_sec_only_dma)
		else $error("secondary register read nonzero outside bit 5");

	property p_sec_dma_raised;
		sec_ctrl_q[`DBMP_BIT_DMA] && i_sec_req == 2'b11 |-> o_sec_gnt == 2'b10;
	endproperty
	a_sec_dma_raised: assert property (p_sec_dma_raised)
		else $error("raised DMA not granted on secondary bus");

	property p_write_read_back;
		i_wr && i_addr == `DBMP_ADDR_MAIN ##1 i_rd && i_addr == `DBMP_ADDR_MAIN
			&& !i_wr |=> o_rdata == ($past(i_wdata, 2) & `DBMP_MASK_MAIN);
	endproperty
	a_write_read_back: assert property (p_write_read_back)
		else $error("main register read-back mismatch");

	property p_reset_clear;
		$fell(i_rst) |-> main_ctrl_q == 16'h0000 && sec_ctrl_q == 16'h0000;
	endproperty
	a_reset_clear: assert property (disable iff (1'b0) p_reset_clear)
		else $error("priority registers not clear after reset");

	property p_sec_separate;
		i_wr && i_addr == `DBMP_ADDR_MAIN |=> sec_ctrl_q == $past(sec_ctrl_q);
	endproperty
	a_sec_separate: assert property (p_sec_separate)
		else $error("main write disturbed secondary register");

	property p_cpu_default;
		!main_ctrl_q[`DBMP_BIT_DMA] && i_main_req[`DBMP_MST_CPU]
			&& !(main_ctrl_q[`DBMP_BIT_CAN] && i_main_req[`DBMP_MST_CAN])
			&& !(main_ctrl_q[`DBMP_BIT_NVM] && i_main_req[`DBMP_MST_NVM])
			|-> o_main_gnt == 4'h1;
	endproperty
	a_cpu_default: assert property (p_cpu_default)
		else $error("CPU lost bus to unraised master");

	property p_gnt_onehot;
		$onehot0(o_main_gnt) && ((o_main_gnt & ~i_main_req) == 4'h0)
			&& ((i_main_req != 4'h0) == (o_main_gnt != 4'h0));
	endproperty
	a_gnt_onehot: assert property (p_gnt_onehot)
		else $error("main grant not one-hot to a requester");

	property p_sec_cpu_default;
		!sec_ctrl_q[`DBMP_BIT_DMA] && i_sec_req == 2'b11 |-> o_sec_gnt == 2'b01;
	endproperty
	a_sec_cpu_default: assert property (p_sec_cpu_default)
		else $error("secondary CPU lost bus to unraised DMA");

	property p_sec_gnt_onehot;
		$onehot0(o_sec_gnt) && ((o_sec_gnt & ~i_sec_req) == 2'b00)
			&& ((i_sec_req != 2'b00) == (o_sec_gnt != 2'b00));
	endproperty
	a_sec_gnt_onehot: assert property (p_sec_gnt_onehot)
		else $error("secondary grant not one-hot to a requester");

	// Read data must not linger, software may poll with back-to-back reads
	property p_rdata_idle;
		!i_rd |=> o_rdata == 16'h0000;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data present without a read strobe");

	property p_unmapped_read_zero;
		i_rd && i_addr != `DBMP_ADDR_MAIN && i_addr != `DBMP_ADDR_SEC
			|=> o_rdata == 16'h0000;
	endproperty
	a_unmapped_read_zero: assert property (p_unmapped_read_zero)
		else $error("unmapped register index read nonzero");

	c_nvm_over_cpu: cover property (main_ctrl_q[`DBMP_BIT_NVM]
		&& i_main_req == 4'h9 ##0 o_main_gnt == 4'h8);
	c_dma_over_cpu: cover property (main_ctrl_q[`DBMP_BIT_DMA]
		&& i_main_req == 4'h3 ##0 o_main_gnt == 4'h2);
	c_can_over_cpu: cover property (o_main_gnt == 4'h4 && i_main_req[`DBMP_MST_CPU]);
	c_sec_dma_over_cpu: cover property (o_sec_gnt == 2'b10 && i_sec_req == 2'b11);
	c_write_then_read: cover property (i_wr ##1 i_rd);

endmodule // dbmp_top

`default_nettype wire

// *** verification/dbmp_master_model.sv ***
/*
 * Far-side bus masters for both cores: random request levels each cycle.
 * Assumes the bench seeds $urandom; requests stay low during reset.
 */
`timescale 1ns/1ps
`default_nettype none

module dbmp_master_model
	import dbmp_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	output dbmp_mvec_t o_main_req,
	output logic [1:0] o_sec_req
);
	// ======================================
	// Requests
	always @(posedge i_mclk) begin
		o_main_req <= i_rst ? 4'h0 : 4'($urandom);
		o_sec_req <= i_rst ? 2'h0 : 2'($urandom);
	end
endmodule // dbmp_master_model

`default_nettype wire

// *** verification/tb.sv ***
/*
 * Self-checking bench for dbmp_top: register port and both arbiters.
 * Assumes dbmp_pkg, dbmp_defs.svh and the master model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dbmp_defs.svh"

module tb;
	import dbmp_pkg::*;
	// ======================================
	// Signals and instances
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	dbmp_addr_t i_addr = 4'h0;
	dbmp_word_t i_wdata = 16'h0000;
	dbmp_word_t o_rdata;
	dbmp_mvec_t main_req, o_main_gnt;
	logic [1:0] sec_req, o_sec_gnt;
	int num_errors = 0;
	int checked = 0;
	dbmp_word_t main_m = 16'h0000;
	dbmp_word_t sec_m = 16'h0000;
	bit mon_on = 1'b0;
	dbmp_addr_t a;

	always #5 i_mclk = ~i_mclk;

	dbmp_top DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_main_req(main_req),
		.o_main_gnt(o_main_gnt), .i_sec_req(sec_req), .o_sec_gnt(o_sec_gnt));
	dbmp_master_model masters (.i_mclk(i_mclk), .i_rst(i_rst), .o_main_req(main_req),
		.o_sec_req(sec_req));

	// ======================================
	// Expectation and checking
	// Up bits: 0 DMA, 1 CAN, 2 NVM
	function automatic dbmp_mvec_t exp_gnt(input dbmp_mvec_t q, input logic [2:0] up);
		if (q[1] & up[0]) return 4'h2;
		if (q[2] & up[1]) return 4'h4;
		if (q[3] & up[2]) return 4'h8;
		if (q[0]) return 4'h1;
		if (q[1]) return 4'h2;
		if (q[2]) return 4'h4;
		if (q[3]) return 4'h8;
		return 4'h0;
	endfunction

	task chk(input dbmp_word_t seen, input dbmp_word_t exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr(input dbmp_addr_t ad, input dbmp_word_t d);
		i_wr <= 1'b1;
		i_addr <= ad;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		if (ad == `DBMP_ADDR_MAIN) main_m = d & `DBMP_MASK_MAIN;
		if (ad == `DBMP_ADDR_SEC) sec_m = d & `DBMP_MASK_SEC;
	endtask

	task rd(input dbmp_addr_t ad, input dbmp_word_t e);
		i_rd <= 1'b1;
		i_addr <= ad;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
		// Hand back on an edge so the next strobe is driven there
		@(posedge i_mclk);
	endtask

	always @(negedge i_mclk) begin
		if (mon_on) begin
			chk({12'h0, o_main_gnt}, {12'h0, exp_gnt(main_req, {main_m[0], main_m[4], main_m[5]})});
			chk({14'h0, o_sec_gnt}, {12'h0, exp_gnt({2'b00, sec_req}, {2'b00, sec_m[5]})});
		end
	end

	task close_out;
		$display("Counts: %0d comparisons, %0d mismatches", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#100000;
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		close_out;
	end

	// ======================================
	// Tests
	initial begin
		void'($urandom(32'hdd94));
		repeat (3) @(posedge i_mclk);
		i_rst <= 1'b0;
		mon_on = 1'b1;
		rd(`DBMP_ADDR_MAIN, 16'h0000);
		rd(`DBMP_ADDR_SEC, 16'h0000);
		$display("test reset_values done");
		wr(`DBMP_ADDR_MAIN, 16'hffff);
		rd(`DBMP_ADDR_MAIN, 16'h0031);
		rd(`DBMP_ADDR_SEC, 16'h0000);
		wr(`DBMP_ADDR_SEC, 16'hffff);
		rd(`DBMP_ADDR_SEC, 16'h0020);
		wr(4'h2, 16'hffff);
		rd(4'h2, 16'h0000);
		rd(`DBMP_ADDR_MAIN, 16'h0031);
		$display("test masks done");
		for (int k = 0; k < 8; k++) begin
			wr(`DBMP_ADDR_MAIN, {10'h0, k[2], k[1], 3'h0, k[0]});
			repeat (8) @(posedge i_mclk);
		end
		$display("test raise_combos done");
		repeat (60) begin
			a = 4'($urandom_range(1));
			wr(a, 16'($urandom));
			repeat ($urandom_range(3)) @(posedge i_mclk);
			rd(a, (a == `DBMP_ADDR_MAIN) ? main_m : sec_m);
		end
		$display("test random_access done");
		wr(`DBMP_ADDR_SEC, 16'hffff);
		wr(`DBMP_ADDR_MAIN, 16'hffff);
		i_rst <= 1'b1;
		@(posedge i_mclk);
		main_m = 16'h0000;
		sec_m = 16'h0000;
		i_rst <= 1'b0;
		rd(`DBMP_ADDR_MAIN, 16'h0000);
		rd(`DBMP_ADDR_SEC, 16'h0000);
		$display("test mid_reset done");
		close_out;
	end
endmodule // tb

`default_nettype wire
